// ### rtl/uiw_pkg.sv
// Constants shared by the serial-port interrupt and wake block
package uiw_pkg;

  // Bus geometry
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFFS   = 4'h0;  // serial_control_two
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 4'h4;  // serial_status_reg
  localparam logic [ADDR_W-1:0] RXDATA_OFFS = 4'h8;  // rx_data_fifo head

  // Control register field positions
  localparam int TXE_IE_BIT    = 0;
  localparam int TXI_IE_BIT    = 1;
  localparam int RX_IE_BIT     = 2;
  localparam int ADDR_DET_BIT  = 3;
  localparam int WAKE_EN_BIT   = 4;
  localparam int NINTH_BIT     = 5;
  localparam int PORT_ON_BIT   = 6;
  localparam int RX_ON_BIT     = 7;
  localparam int PARITY_BIT    = 8;
  localparam int CTRL_W        = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // Status register field positions
  localparam int ST_TXE_BIT    = 0;
  localparam int ST_TXI_BIT    = 1;
  localparam int ST_RXAV_BIT   = 2;
  localparam int ST_OVR_BIT    = 3;
  localparam int ST_ADDR_BIT   = 4;
  localparam int ST_IGN_BIT    = 5;
  localparam int STATUS_W      = 6;

  // Received word layout
  localparam int RXWORD_W      = 9;
  localparam int TOP8_BIT      = 7;
  localparam int TOP9_BIT      = 8;

  // Start-up delay after a wake-up
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_NS    = 10240;
  localparam int STARTUP_CYC   = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power states of the processor
  typedef enum logic [1:0] {
    UIW_PWR_RUN,
    UIW_PWR_ASLEEP,
    UIW_PWR_STARTUP
  } uiw_pwr_e;

endpackage : uiw_pkg

// ### rtl/uiw_sync2.sv
// Two-stage synchroniser for the RX pin
`timescale 1ns/10ps
module uiw_sync2 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Asynchronous level in, synchronised level out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic meta_r;

  // Idle line is high, so reset to one to avoid a false falling edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r  <= 1'b1;
      syncOut <= 1'b1;
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule : uiw_sync2

// ### rtl/uiw_top.sv
// Serial-port interrupt request, address-detect and RX wake-up logic
//
// Summary of operation
// RL1: Five sources feed the port interrupt.
// RL2: Request issued as one-cycle low pulse.
// RL3: Own tx enables; receive sources share one.
// RL4: Vector only when enabled and stack free.
// RL5: Flags read-only; cleared by hardware access only.
// RL6: Processor-level port enable masks whole interrupt.
// RL7: Address detect needs top bit set.
// RL8: Top bit is ninth or eighth bit.
// RL9: Top bit set marks word as address.
// RL10: No address detect: every word interrupts.
// RL11: Software keeps parity off with address detect.
// RL12: RX falling edge wakes when armed beforehand.
// RL13: Wake interrupts only with both global enables.
// RL14: RX data ignored during start-up delay.
// RL15: Wake interrupt waits for start-up delay.
// RL16: Stopped clock pauses transfers, resumes later.
// RL17: Sleep entry leaves registers unchanged.
// RL18: Software finishes transfers before sleeping.
// RL19: Overrun interrupts when receive enable set.
// RL20: Avail flag clears on status then data read.
// RL21: Request is OR of gated sources.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module uiw_top
  import uiw_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output logic [DATA_W-1:0]      readdata,
  output logic                   waitrequest,
  // Transmitter and receiver conditions
  input  wire logic                txEmpty,
  input  wire logic                txIdle,
  input  wire logic                rxWordDone,
  input  wire logic                rxOverrun,
  input  wire logic [RXWORD_W-1:0] rxWord,
  // RX pin, asynchronous
  input  wire logic                rxPin,
  // Processor interrupt and power control
  input  wire logic                global_int_en,
  input  wire logic                port_int_en,
  input  wire logic                stackFull,
  input  wire logic                sleepMode,
  output logic                     intReqN,
  output logic                     wakeReq,
  output logic                     rxIgnore
);

  // Elaboration check: the start-up counter is sixteen bits wide
  if (STARTUP_COUNT < 1 || STARTUP_COUNT > 65535) begin : g_bad_startup
    $error("STARTUP_COUNT out of range");
  end

  // Top received bit, chosen by word length
  function automatic logic topBit(input logic [RXWORD_W-1:0] w, input logic nine);
    topBit = nine ? w[TOP9_BIT] : w[TOP8_BIT];
  endfunction : topBit

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [CTRL_W-1:0]   ctrl_r;
  logic                rxAvail_r;
  logic                overrun_r;
  logic                isAddr_r;
  logic                statusSeen_r;
  logic                txEmptyDly_r;
  logic                txIdleDly_r;
  logic                rxPinDly_r;
  logic                pend_r;
  logic                armed_r;
  logic                sleepDly_r;
  logic                wakeFire_r;
  logic [15:0]         startCnt_r;
  uiw_pwr_e            pwr_r;
  logic                rxPinSync;

  uiw_sync2 uiw_sync2_i (
    .clk     (clk),
    .rstn    (rstn),
    .asyncIn (rxPin),
    .syncOut (rxPinSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire busReq     = read | write;
  wire accept     = busReq & ~waitrequest;
  wire hitCtrl    = (address == CTRL_OFFS);
  wire hitStatus  = (address == STATUS_OFFS);
  wire hitRxData  = (address == RXDATA_OFFS);
  wire wrCtrl     = accept & write & hitCtrl;
  wire statusAcc  = accept & hitStatus;
  wire rxDataRd   = accept & read & hitRxData;

  // Control fields
  wire txeIe      = ctrl_r[TXE_IE_BIT];
  wire txiIe      = ctrl_r[TXI_IE_BIT];
  wire rx_int_en  = ctrl_r[RX_IE_BIT];
  wire addr_detect_en = ctrl_r[ADDR_DET_BIT];
  wire wakeEn     = ctrl_r[WAKE_EN_BIT];
  wire ninth_bit_sel  = ctrl_r[NINTH_BIT];
  wire serial_port_on = ctrl_r[PORT_ON_BIT];
  wire receiver_on    = ctrl_r[RX_ON_BIT];

  // Byte-lane merge for control writes
  wire [DATA_W-1:0] ctrlWide = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
  wire [DATA_W-1:0] beMask   = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [DATA_W-1:0] ctrlMrg  = (writedata & beMask) | (ctrlWide & ~beMask);

  // Status image; flags are read-only, a write leaves them unchanged but counts as the status access
  wire [STATUS_W-1:0] statusImg = {rxIgnore, isAddr_r, overrun_r, rxAvail_r, txIdle, txEmpty};  // see RL5
  wire [DATA_W-1:0]   rdMux = hitCtrl   ? ctrlWide :
                              hitStatus ? {{(DATA_W-STATUS_W){1'b0}}, statusImg} :
                              hitRxData ? {{(DATA_W-RXWORD_W){1'b0}}, rxWord} : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Source conditions
  wire wordTaken  = rxWordDone & ~rxIgnore;                          // see RL14
  wire wordTop    = topBit(rxWord, ninth_bit_sel);                   // see RL8
  wire dataAvail  = wordTaken & (~addr_detect_en | wordTop);         // see RL7, RL10
  wire srcTxe     = txEmpty & ~txEmptyDly_r & txeIe;                 // see RL3
  wire srcTxi     = txIdle & ~txIdleDly_r & txiIe;                   // see RL3
  wire srcRxAv    = dataAvail & rx_int_en;                           // see RL3
  wire srcOvr     = rxOverrun & ~rxIgnore & rx_int_en;               // see RL19
  wire srcHit     = srcTxe | srcTxi | srcRxAv | srcOvr | wakeFire_r; // see RL1, RL21
  wire gateOpen   = global_int_en & port_int_en & ~stackFull;        // see RL4, RL6
  wire clrFlags   = rxDataRd & statusSeen_r;                         // see RL20

  // Wake conditions
  wire armNow     = wakeEn & serial_port_on & receiver_on & rx_int_en;
  wire sleepRise  = sleepMode & ~sleepDly_r;
  wire rxFall     = ~rxPinSync & rxPinDly_r;
  wire startDone  = (startCnt_r == 16'(STARTUP_COUNT - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, then the answer for one edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= '0;
    end else begin
      waitrequest <= ~(busReq & waitrequest);
      if (busReq & waitrequest) begin
        readdata <= read ? rdMux : '0;
      end
    end
  end

  // Control register; sleep entry does not touch it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_r <= ctrlMrg[CTRL_W-1:0];  // see RL17
    end
  end

  // Receive flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rxAvail_r    <= 1'b0;
      overrun_r    <= 1'b0;
      isAddr_r     <= 1'b0;
      statusSeen_r <= 1'b0;
    end else begin
      rxAvail_r    <= wordTaken | (rxAvail_r & ~clrFlags);                // see RL20, RL5
      overrun_r    <= (rxOverrun & ~rxIgnore) | (overrun_r & ~clrFlags);  // see RL5
      if (wordTaken) begin
        isAddr_r <= wordTop;  // see RL9
      end
      statusSeen_r <= statusAcc | (statusSeen_r & ~rxDataRd);
    end
  end

  // Edge history for level sources and the pin
  always_ff @(posedge clk) begin
    if (!rstn) begin
      txEmptyDly_r <= 1'b0;
      txIdleDly_r  <= 1'b0;
      rxPinDly_r   <= 1'b1;
      sleepDly_r   <= 1'b0;
    end else begin
      txEmptyDly_r <= txEmpty;
      txIdleDly_r  <= txIdle;
      rxPinDly_r   <= rxPinSync;
      sleepDly_r   <= sleepMode;
    end
  end

  // Pending request, issued as one low cycle once the gate opens
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_r  <= 1'b0;
      intReqN <= 1'b1;
    end else begin
      intReqN <= ~(pend_r & gateOpen & intReqN);            // see RL2, RL4
      pend_r  <= srcHit | (pend_r & ~(gateOpen & intReqN)); // see RL21
    end
  end

  // Power sequencer; holds state only, so a stopped clock simply pauses it
  always_ff @(posedge clk) begin  // see RL16
    if (!rstn) begin
      pwr_r      <= UIW_PWR_RUN;
      armed_r    <= 1'b0;
      wakeReq    <= 1'b0;
      rxIgnore   <= 1'b0;
      wakeFire_r <= 1'b0;
      startCnt_r <= '0;
    end else begin
      wakeReq    <= 1'b0;
      wakeFire_r <= 1'b0;
      case (pwr_r)
        UIW_PWR_RUN: begin
          if (sleepRise) begin
            armed_r <= armNow;  // see RL12
            pwr_r   <= UIW_PWR_ASLEEP;
          end
        end
        UIW_PWR_ASLEEP: begin
          if (!sleepMode) begin
            pwr_r <= UIW_PWR_RUN;
          end else if (armed_r & rxFall) begin
            wakeReq    <= 1'b1;  // see RL12
            rxIgnore   <= 1'b1;  // see RL14
            startCnt_r <= '0;
            pwr_r      <= UIW_PWR_STARTUP;
          end
        end
        UIW_PWR_STARTUP: begin
          startCnt_r <= startCnt_r + 16'h0001;
          if (startDone) begin
            rxIgnore   <= 1'b0;
            wakeFire_r <= global_int_en & port_int_en;  // see RL13, RL15
            armed_r    <= 1'b0;
            pwr_r      <= UIW_PWR_RUN;
          end
        end
        default: begin
          pwr_r <= UIW_PWR_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_low_pulse;
    @(posedge clk) disable iff (!rstn) !intReqN |=> intReqN;
  endproperty
  a_low_pulse: assert property (p_low_pulse) else $error("request low longer than one cycle");  // see RL2

  property p_gate;
    @(posedge clk) disable iff (!rstn) $fell(intReqN) |-> $past(gateOpen) && $past(pend_r);
  endproperty
  a_gate: assert property (p_gate) else $error("request issued while masked");  // see RL4

  property p_pend_served;
    @(posedge clk) disable iff (!rstn) pend_r && gateOpen && intReqN |=> !intReqN;
  endproperty
  a_pend_served: assert property (p_pend_served) else $error("open gate did not issue request");  // see RL6

  property p_addr_block;
    @(posedge clk) disable iff (!rstn) wordTaken && addr_detect_en && !wordTop && !pend_r &&
      !srcTxe && !srcTxi && !srcOvr && !wakeFire_r |=> !pend_r;
  endproperty
  a_addr_block: assert property (p_addr_block) else $error("data word passed address detect");  // see RL7

  property p_no_addr;
    @(posedge clk) disable iff (!rstn) wordTaken && rx_int_en && !addr_detect_en |=> pend_r;
  endproperty
  a_no_addr: assert property (p_no_addr) else $error("word did not raise pending");  // see RL10

  property p_flag_clear;
    @(posedge clk) disable iff (!rstn) $fell(rxAvail_r) |-> $past(rxDataRd) && $past(statusSeen_r);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("avail flag cleared wrongly");  // see RL20

  property p_set_wins;
    @(posedge clk) disable iff (!rstn) wordTaken |=> rxAvail_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("word lost against clear");  // see RL5

  property p_wake_cause;
    @(posedge clk) disable iff (!rstn) wakeReq |-> $past(armed_r) && $past(rxFall) && rxIgnore;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without armed falling edge");  // see RL12

  property p_wake_late;
    @(posedge clk) disable iff (!rstn) wakeFire_r |-> $past(rxIgnore) && !rxIgnore;
  endproperty
  a_wake_late: assert property (p_wake_late) else $error("wake interrupt before start-up end");  // see RL15

  property p_sleep_keep;
    @(posedge clk) disable iff (!rstn) sleepRise && !wrCtrl |=> $stable(ctrl_r);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep entry changed control");  // see RL17

  property p_ignore;
    @(posedge clk) disable iff (!rstn) rxIgnore && !clrFlags |=> $stable(rxAvail_r) && $stable(overrun_r);
  endproperty
  a_ignore: assert property (p_ignore) else $error("word taken during start-up");  // see RL14

  c_req: cover property (@(posedge clk) disable iff (!rstn) $fell(intReqN));
  c_wake: cover property (@(posedge clk) disable iff (!rstn) wakeFire_r);
  c_clear: cover property (@(posedge clk) disable iff (!rstn) clrFlags && wordTaken);
  c_addr: cover property (@(posedge clk) disable iff (!rstn) wordTaken && addr_detect_en && wordTop);

endmodule : uiw_top

// ### tb/uiw_cpu_model.sv
// Processor power-mode model facing the block's wake output
`timescale 1ns/10ps
module uiw_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Bench requests: enter sleep, leave for another reason
  input  wire logic sleepGo,
  input  wire logic wakeOther,
  // Wake request from the block
  input  wire logic wakeReq,
  // Power state seen by the block
  output logic      sleepMode
);
  logic sleepMode_r;

  // Sleeps only when told, with no check on bus traffic; any wake leaves it
  always_ff @(posedge clk) begin
    if (!rstn)
      sleepMode_r <= 1'b0;
    else if (wakeReq || wakeOther)
      sleepMode_r <= 1'b0;
    else if (sleepGo)
      sleepMode_r <= 1'b1;
  end
  assign sleepMode = sleepMode_r;
endmodule : uiw_cpu_model

// ### tb/uiw_top_tb.sv
// Self-checking bench for the serial-port interrupt and wake block
`timescale 1ns/10ps
module uiw_top_tb;
  import uiw_pkg::*;
  localparam int SC = 4;  // Short start-up so wake runs stay brief
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0]        byteenable = 4'hf;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic              txEmpty = 1'b0;
  logic              txIdle = 1'b0;
  logic              rxWordDone = 1'b0;
  logic              rxOverrun = 1'b0;
  logic [8:0]        rxWord = '0;
  logic              rxPin = 1'b1;
  logic              globalEn = 1'b1;
  logic              portEn = 1'b1;
  logic              stackFull = 1'b0;
  logic              sleepGo = 1'b0;
  logic              wakeOther = 1'b0;
  logic              sleepMode, intReqN, wakeReq, rxIgnore;
  int                cyc = 0, nFail = 0, checks = 0, note;
  int                intQ[$];
  logic [DATA_W-1:0] rdQ[$];

  uiw_top #(.STARTUP_COUNT(SC)) uiw_top_i (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .txEmpty(txEmpty), .txIdle(txIdle), .rxWordDone(rxWordDone),
    .rxOverrun(rxOverrun), .rxWord(rxWord), .rxPin(rxPin), .global_int_en(globalEn),
    .port_int_en(portEn), .stackFull(stackFull), .sleepMode(sleepMode), .intReqN(intReqN),
    .wakeReq(wakeReq), .rxIgnore(rxIgnore));
  uiw_cpu_model uiw_cpu_model_i (.clk(clk), .rstn(rstn), .sleepGo(sleepGo), .wakeOther(wakeOther),
    .wakeReq(wakeReq), .sleepMode(sleepMode));

  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Scoreboard: each low pulse or read answer takes the oldest note; 0 means any cycle
  always @(posedge clk) begin
    if (rstn && intReqN !== 1'b1) begin
      note = (intQ.size() > 0) ? intQ.pop_front() : -1;
      if (note != 0)
        chk("intReqN cycle", note, cyc);
    end
    if (read && waitrequest === 1'b0)
      chk("readdata", rdQ.pop_front(), readdata);
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : printVerdict

  ////////////////////////////////////////////////////////////////////////////
  // Avalon cycle: hold everything until waitrequest is sampled low
  task automatic bus(logic wr, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic [3:0] be);
    int n;
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    chk("bus answer", 1, n < 50);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, a, '0, 4'hf);
  endtask : rd

  // One-cycle source event; a pulse is noted for two edges after it is sampled
  task automatic ev(int src, bit exp);
    @(posedge clk);
    case (src)
      0: txEmpty <= 1'b1;
      1: txIdle <= 1'b1;
      2: rxWordDone <= 1'b1;
      default: rxOverrun <= 1'b1;
    endcase
    if (exp)
      intQ.push_back(cyc + 3);
    @(posedge clk);
    txEmpty <= 1'b0;
    txIdle <= 1'b0;
    rxWordDone <= 1'b0;
    rxOverrun <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : ev

  // Sleep, drop the RX pin, then follow wake timing and the ignore window
  task automatic wk(logic [DATA_W-1:0] c, bit armed, bit irq);
    int n, t;
    wr(CTRL_OFFS, c);
    sleepGo <= 1'b1;
    @(posedge clk);
    sleepGo <= 1'b0;
    repeat (3) @(posedge clk);
    if (irq)
      intQ.push_back(0);
    rxPin <= 1'b0;
    t = cyc + 4;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wakeReq !== 1'b1 && n < 20);
    chk("wakeReq seen", armed, n < 20);
    if (armed) begin
      chk("wakeReq cycle", t, cyc);
      n = 0;
      while (rxIgnore === 1'b1 && n < 50) begin
        n++;
        @(posedge clk);
      end
      chk("rxIgnore span", SC, n);
      chk("sleepMode", 0, sleepMode);
    end
    repeat (12) @(posedge clk);
    rxPin <= 1'b1;
    wakeOther <= 1'b1;
    @(posedge clk);
    wakeOther <= 1'b0;
    rd(CTRL_OFFS, c);
    $display("test wake armed=%0d irq=%0d done", armed, irq);
  endtask : wk

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (6000) @(posedge clk);
    nFail++;
    $display("watchdog expired");
    printVerdict();
  end

  initial begin
    logic [DATA_W-1:0] c;
    int top;
    logic [8:0] w;
    void'($urandom(32'haf40));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // Register reset, byte lanes and unmapped place
    rd(CTRL_OFFS, 32'h0);
    rd(STATUS_OFFS, 32'h0);
    wr(CTRL_OFFS, 32'h1ff);
    wr(CTRL_OFFS, 32'h0);
    wr(CTRL_OFFS, 32'h0);
    bus(1'b1, CTRL_OFFS, 32'h0, 4'h2);
    rd(CTRL_OFFS, 32'h0);
    wr(CTRL_OFFS, 32'h1ff);
    bus(1'b1, CTRL_OFFS, 32'h0, 4'h2);
    rd(CTRL_OFFS, 32'h0ff);
    wr(4'hc, 32'h5);
    rd(4'hc, 32'h0);
    $display("test registers done");
    // Each source alone on its own enable, then with only its own enable off
    for (int s = 0; s < 4; s++) begin
      top = (s < 2) ? s : 2;
      wr(CTRL_OFFS, (32'h1 << top) | 32'h0c0);
      ev(s, 1);
      wr(CTRL_OFFS, 32'h0c7 & ~(32'h1 << top));
      ev(s, 0);
    end
    $display("test sources done");
    // Address detect over word size and top bit, parity kept off
    for (int k = 0; k < 8; k++) begin
      top = k & 1;
      c = 32'h0c4 | ((k & 2) ? 32'h8 : 32'h0) | ((k & 4) ? 32'h20 : 32'h0);
      wr(CTRL_OFFS, c);
      w = 9'($urandom);
      w[8] = (k & 4) ? top[0] : ~top[0];
      w[7] = (k & 4) ? ~top[0] : top[0];
      @(posedge clk);
      rxWord <= w;
      ev(2, !(k & 2) || top);
    end
    $display("test address detect done");
    // Closed gates keep the request pending until they open
    for (int g = 0; g < 3; g++) begin
      @(posedge clk);
      globalEn <= (g != 0);
      portEn <= (g != 1);
      stackFull <= (g == 2);
      intQ.push_back(0);
      ev(3, 0);
      chk("held pending", 1, intQ.size());
      globalEn <= 1'b1;
      portEn <= 1'b1;
      stackFull <= 1'b0;
      repeat (8) @(posedge clk);
      chk("pending issued", 0, intQ.size());
    end
    $display("test gates done");
    // Flags ignore writes and clear on status access then word read
    wr(CTRL_OFFS, 32'h0c4);
    @(posedge clk);
    rxWord <= 9'h05a;
    ev(3, 1);
    ev(2, 1);
    wr(STATUS_OFFS, 32'h3f);
    rd(STATUS_OFFS, 32'h0c);
    rd(RXDATA_OFFS, 32'h05a);
    rd(STATUS_OFFS, 32'h00);
    $display("test flags done");
    wk(32'h0d4, 1, 1);
    wk(32'h0c4, 0, 0);
    globalEn <= 1'b0;
    wk(32'h0d4, 1, 0);
    chk("notes left", 0, intQ.size());
    printVerdict();
  end
endmodule : uiw_top_tb
